// >>> verilog/tcpwm_pkg.sv
// Constants shared by the three-phase complementary PWM generator.
package tcpwm_pkg;
   localparam int unsigned TCPWM_DW = 16;
   localparam int unsigned TCPWM_AW = 4;
   localparam int unsigned TCPWM_PHASES = 3;
   // System clock cycles per counter clock tick.
   localparam int unsigned TCPWM_PRESCALE = 4;
   localparam int unsigned TCPWM_PSW = 2;
   // Register indexes on the plain register port.
   localparam logic [3:0] TCPWM_OFS_CTRL = 4'h0;
   localparam logic [3:0] TCPWM_OFS_DEAD = 4'h1;
   localparam logic [3:0] TCPWM_OFS_HALF = 4'h2;
   localparam logic [3:0] TCPWM_OFS_HALF_BUF = 4'h3;
   localparam logic [3:0] TCPWM_OFS_UPPER = 4'h4;
   localparam logic [3:0] TCPWM_OFS_UPPER_BUF = 4'h5;
   localparam logic [3:0] TCPWM_OFS_BUF1 = 4'h6;
   localparam logic [3:0] TCPWM_OFS_BUF3 = 4'h8;
   localparam logic [3:0] TCPWM_OFS_CMP1 = 4'h9;
   localparam logic [3:0] TCPWM_OFS_CMP3 = 4'hB;
   localparam logic [3:0] TCPWM_OFS_CNT1 = 4'hC;
   localparam logic [3:0] TCPWM_OFS_CNT2 = 4'hD;
   localparam logic [3:0] TCPWM_OFS_STATUS = 4'hE;
   // Control register field positions and reset value.
   localparam int unsigned TCPWM_CTRL_W = 6;
   localparam int unsigned TCPWM_CB_START = 0;
   localparam int unsigned TCPWM_CB_TOGGLE_EN = 1;
   localparam int unsigned TCPWM_CB_POS_LVL = 2;
   localparam int unsigned TCPWM_CB_ANTI_LVL = 3;
   localparam int unsigned TCPWM_CB_XFER_PEAK = 4;
   localparam int unsigned TCPWM_CB_XFER_TROUGH = 5;
   localparam logic [5:0] TCPWM_CTRL_RST = 6'h30;
   // Status register field positions.
   localparam int unsigned TCPWM_SB_DOWN1 = 0;
   localparam int unsigned TCPWM_SB_DOWN2 = 1;
   localparam int unsigned TCPWM_SB_PENDING = 2;
   localparam int unsigned TCPWM_SB_TOGGLE = 3;
   localparam int unsigned TCPWM_SB_RUN = 4;
   // Reset values of data registers and pins.
   localparam logic [15:0] TCPWM_DATA_RST = 16'h0000;
   localparam logic [15:0] TCPWM_COUNT_ZERO = 16'h0000;
   localparam logic TCPWM_PIN_RST = 1'b1;
endpackage

// >>> verilog/tcpwm_prescale.sv
// Counter clock divider producing a one-cycle tick enable.
`timescale 1ns/100ps
module tcpwm_prescale
   import tcpwm_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Control and tick.
   input wire logic run,
   output logic tick
);
   typedef struct packed {
      logic [TCPWM_PSW-1:0] count;
      logic tick;
   } tcpwm_ps_state_t;

   tcpwm_ps_state_t st_r;
   tcpwm_ps_state_t st_nxt;

   localparam logic [TCPWM_PSW-1:0] LAST = TCPWM_PSW'(TCPWM_PRESCALE - 1);

   // The divider is held clear while stopped so every start is aligned.
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!run) begin
         st_nxt.count = '0;
      end else if (st_r.count == LAST) begin
         st_nxt.count = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.count = st_r.count + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

   chk_tick_spacing: assert property (@(posedge clk) disable iff (reset)
      tick |=> !tick [*3]) else $error("counter tick came too soon");
endmodule // tcpwm_prescale

// >>> verilog/tcpwm_phase.sv
// One phase of positive and antiphase outputs with level selection.
`timescale 1ns/100ps
module tcpwm_phase
   import tcpwm_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Counters and limits.
   input wire logic [15:0] cnt1,
   input wire logic [15:0] cnt2,
   input wire logic down,
   input wire logic [15:0] duty,
   input wire logic [15:0] upper,
   input wire logic [15:0] dead,
   // Level selects, low means active low.
   input wire logic pos_lvl,
   input wire logic anti_lvl,
   // Pins.
   output logic pos_pin,
   output logic anti_pin
);
   typedef struct packed {
      logic pos;
      logic anti;
   } tcpwm_ph_state_t;

   tcpwm_ph_state_t st_r;
   tcpwm_ph_state_t st_nxt;
   logic pos_act;
   logic anti_act;

   always_comb begin
      if (duty == TCPWM_COUNT_ZERO) begin
         pos_act = 1'b1;
         anti_act = 1'b0;
      end else if (duty >= upper) begin
         pos_act = 1'b0;
         anti_act = 1'b1;
      end else begin
         // Positive rests while the lagging counter is below the duty and
         // antiphase while the leading one is above it, so both rest in
         // the dead band. The direction decides which slope owns an equal
         // count, which keeps every width an exact number of ticks.
         pos_act = (cnt2 > duty) || (cnt2 == duty && down);
         anti_act = (cnt1 < duty) || (cnt1 == duty && !down);
      end
      st_nxt.pos = pos_act ? pos_lvl : !pos_lvl;
      st_nxt.anti = anti_act ? anti_lvl : !anti_lvl;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= {TCPWM_PIN_RST, TCPWM_PIN_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pos_pin = st_r.pos;
   assign anti_pin = st_r.anti;

   chk_zero_duty: assert property (@(posedge clk) disable iff (reset)
      (duty == 16'h0000) |=>
      (pos_pin == $past(pos_lvl) && anti_pin != $past(anti_lvl)))
      else $error("zero duty did not fix outputs");
   chk_full_duty: assert property (@(posedge clk) disable iff (reset)
      (duty != 16'h0000 && duty >= upper) |=>
      (pos_pin != $past(pos_lvl) && anti_pin == $past(anti_lvl)))
      else $error("full duty did not fix outputs");
   chk_no_overlap: assert property (@(posedge clk) disable iff (reset)
      (duty != 16'h0000 && duty < upper && dead != 16'h0000
       && cnt1 > cnt2 && cnt1 - cnt2 == dead) |=>
      !(pos_pin == $past(pos_lvl) && anti_pin == $past(anti_lvl)))
      else $error("positive and antiphase both active");
endmodule // tcpwm_phase

// >>> verilog/tcpwm_top.sv
// Three-phase complementary PWM generator with dead time and buffering.
`timescale 1ns/100ps
// Operation
// - Both counters count up and down, turning instead of wrapping.
// - Both counters start on the same counter clock tick.
// - Counter one turns down at upper limit, up at dead time.
// - Counter two turns down at half carrier, up at zero.
// - Half carrier register holds half the carrier period, sets timing.
// - Compare matches set phase outputs to selected levels.
// - Counter peak raises an interrupt request once per carrier.
// - Three duty buffers, one per phase, take software duty changes.
// - Buffered duties pass through hidden temporary registers first.
// - Toggle enable inverts a pin at every counter one turning point.
// - Toggle pin starts low.
// - Zero duty: positive 0 percent, antiphase 100 percent.
// - Duty at or above upper: positive 100, antiphase 0 percent.
// - Duty between half and upper: antiphase pulse below twice dead.
// - Duty equal half: antiphase pulse exactly twice dead time.
// - Between dead and half: antiphase equals positive low plus twice dead.
// - Duty equal dead: positive pulse twice dead, antiphase full.
// - Below dead: positive pulse under twice dead, antiphase full.
// - Positive and antiphase outputs are active low with the reset control levels.
module tcpwm_top
   import tcpwm_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Register port.
   input wire logic [TCPWM_AW-1:0] addr,
   input wire logic [TCPWM_DW-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [TCPWM_DW-1:0] rdata,
   // Events.
   output logic peak_irq,
   output logic carrier_toggle_pin,
   // Phase pins.
   output logic phase_one_positive_pin,
   output logic phase_one_anti_pin,
   output logic phase_two_positive_pin,
   output logic phase_two_anti_pin,
   output logic phase_three_positive_pin,
   output logic phase_three_anti_pin
);
   typedef struct packed {
      logic [TCPWM_CTRL_W-1:0] ctrl;
      logic [15:0] dead_time_value;
      logic [15:0] half_carrier_value;
      logic [15:0] half_carrier_buffer;
      logic [15:0] upper_limit_compare;
      logic [15:0] upper_limit_buffer;
      logic [TCPWM_PHASES-1:0][15:0] duty_buf;
      logic [TCPWM_PHASES-1:0][15:0] duty_tmp;
      logic [15:0] half_tmp;
      logic [15:0] upper_tmp;
      logic [TCPWM_PHASES-1:0][15:0] duty_cmp;
      logic tmp_valid;
      logic [15:0] first_phase_counter;
      logic [15:0] second_phase_counter;
      logic down1;
      logic down2;
      logic toggle;
      logic irq;
      logic [15:0] rdata;
   } tcpwm_state_t;

   tcpwm_state_t st_r;
   tcpwm_state_t st_nxt;
   logic tick;
   logic run;
   logic peak_ev;
   logic trough_ev;
   logic xfer_ev;
   logic [TCPWM_PHASES-1:0] pos_pins;
   logic [TCPWM_PHASES-1:0] anti_pins;

   // Steps a triangle counter one count in its direction.
   function automatic logic [15:0] cnt_step(input logic [15:0] cnt,
                                            input logic down);
      cnt_step = down ? cnt - 16'h0001 : cnt + 16'h0001;
   endfunction

   // Tells whether an address selects a phase register of a given base.
   function automatic logic in_phase(input logic [3:0] a,
                                     input logic [3:0] base);
      in_phase = (a >= base) && (a < base + 4'h3);
   endfunction

   assign run = st_r.ctrl[TCPWM_CB_START];

   // One divider feeds both counters, so neither can run ahead.
   tcpwm_prescale u_prescale (
      .clk(clk),
      .reset(reset),
      .run(run),
      .tick(tick)
   );

   assign peak_ev = tick && !st_r.down1
      && st_r.first_phase_counter == st_r.upper_limit_compare;
   assign trough_ev = tick && st_r.down1
      && st_r.first_phase_counter == st_r.dead_time_value;
   assign xfer_ev = st_r.tmp_valid
      && ((peak_ev && st_r.ctrl[TCPWM_CB_XFER_PEAK])
      || (trough_ev && st_r.ctrl[TCPWM_CB_XFER_TROUGH]));

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = TCPWM_DATA_RST;
      st_nxt.irq = peak_ev;

      // Counter one turns at the upper limit and at the dead time.
      if (tick) begin
         if (st_r.first_phase_counter == st_r.upper_limit_compare) begin
            st_nxt.down1 = 1'b1;
         end else if (st_r.first_phase_counter == st_r.dead_time_value) begin
            st_nxt.down1 = 1'b0;
         end
         if (st_r.second_phase_counter == st_r.half_carrier_value) begin
            st_nxt.down2 = 1'b1;
         end else if (st_r.second_phase_counter == TCPWM_COUNT_ZERO) begin
            st_nxt.down2 = 1'b0;
         end
         st_nxt.first_phase_counter =
            cnt_step(st_r.first_phase_counter, st_nxt.down1);
         st_nxt.second_phase_counter =
            cnt_step(st_r.second_phase_counter, st_nxt.down2);
      end

      if ((peak_ev || trough_ev) && st_r.ctrl[TCPWM_CB_TOGGLE_EN]) begin
         st_nxt.toggle = !st_r.toggle;
      end

      // While running, temporaries reach the compare registers only at a chosen turn.
      if (xfer_ev) begin
         st_nxt.duty_cmp = st_r.duty_tmp;
         st_nxt.half_carrier_value = st_r.half_tmp;
         st_nxt.upper_limit_compare = st_r.upper_tmp;
         st_nxt.tmp_valid = 1'b0;
      end

      if (wr) begin
         case (addr)
            TCPWM_OFS_CTRL: begin
               st_nxt.ctrl = wdata[TCPWM_CTRL_W-1:0];
            end
            TCPWM_OFS_DEAD: begin
               if (!run) begin
                  st_nxt.dead_time_value = wdata;
               end
            end
            TCPWM_OFS_HALF: begin
               if (!run) begin
                  st_nxt.half_carrier_value = wdata;
               end
            end
            TCPWM_OFS_HALF_BUF: begin
               st_nxt.half_carrier_buffer = wdata;
            end
            TCPWM_OFS_UPPER_BUF: begin
               st_nxt.upper_limit_buffer = wdata;
            end
            TCPWM_OFS_UPPER: begin
               if (!run) begin
                  st_nxt.upper_limit_compare = wdata;
               end
            end
            TCPWM_OFS_CNT1: begin
               if (!run) begin
                  st_nxt.first_phase_counter = wdata;
                  st_nxt.down1 = 1'b0;
               end
            end
            TCPWM_OFS_CNT2: begin
               if (!run) begin
                  st_nxt.second_phase_counter = wdata;
                  st_nxt.down2 = 1'b0;
               end
            end
            default: begin
               if (in_phase(addr, TCPWM_OFS_BUF1)) begin
                  st_nxt.duty_buf[addr - TCPWM_OFS_BUF1] = wdata;
               end
            end
         endcase
         // The last phase buffer write arms the whole set; a write that
         // meets a transfer re-arms, so the new set is never lost.
         if (addr == TCPWM_OFS_BUF3) begin
            st_nxt.duty_tmp = {wdata, st_r.duty_buf[1],
                               st_r.duty_buf[0]};
            st_nxt.half_tmp = st_r.half_carrier_buffer;
            st_nxt.upper_tmp = st_r.upper_limit_buffer;
            st_nxt.tmp_valid = 1'b1;
            if (!run) begin
               // Stopped: no turning point will come, so load at once.
               st_nxt.duty_cmp = st_nxt.duty_tmp;
               st_nxt.half_carrier_value = st_r.half_carrier_buffer;
               st_nxt.upper_limit_compare = st_r.upper_limit_buffer;
               st_nxt.tmp_valid = 1'b0;
            end
         end
      end

      if (rd) begin
         case (addr)
            TCPWM_OFS_CTRL: begin
               st_nxt.rdata = {10'h000, st_r.ctrl};
            end
            TCPWM_OFS_DEAD: begin
               st_nxt.rdata = st_r.dead_time_value;
            end
            TCPWM_OFS_HALF: begin
               st_nxt.rdata = st_r.half_carrier_value;
            end
            TCPWM_OFS_HALF_BUF: begin
               st_nxt.rdata = st_r.half_carrier_buffer;
            end
            TCPWM_OFS_UPPER: begin
               st_nxt.rdata = st_r.upper_limit_compare;
            end
            TCPWM_OFS_UPPER_BUF: begin
               st_nxt.rdata = st_r.upper_limit_buffer;
            end
            TCPWM_OFS_CNT1: begin
               st_nxt.rdata = st_r.first_phase_counter;
            end
            TCPWM_OFS_CNT2: begin
               st_nxt.rdata = st_r.second_phase_counter;
            end
            TCPWM_OFS_STATUS: begin
               st_nxt.rdata[TCPWM_SB_DOWN1] = st_r.down1;
               st_nxt.rdata[TCPWM_SB_DOWN2] = st_r.down2;
               st_nxt.rdata[TCPWM_SB_PENDING] = st_r.tmp_valid;
               st_nxt.rdata[TCPWM_SB_TOGGLE] = st_r.toggle;
               st_nxt.rdata[TCPWM_SB_RUN] = run;
            end
            default: begin
               if (in_phase(addr, TCPWM_OFS_BUF1)) begin
                  st_nxt.rdata = st_r.duty_buf[addr - TCPWM_OFS_BUF1];
               end else if (in_phase(addr, TCPWM_OFS_CMP1)) begin
                  st_nxt.rdata = st_r.duty_cmp[addr - TCPWM_OFS_CMP1];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= '0;
         st_r.ctrl <= TCPWM_CTRL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   generate
      for (genvar i = 0; i < TCPWM_PHASES; i++) begin : g_phase
         tcpwm_phase u_phase (
            .clk(clk),
            .reset(reset),
            .cnt1(st_r.first_phase_counter),
            .cnt2(st_r.second_phase_counter),
            .down(st_r.down2),
            .duty(st_r.duty_cmp[i]),
            .upper(st_r.upper_limit_compare),
            .dead(st_r.dead_time_value),
            .pos_lvl(st_r.ctrl[TCPWM_CB_POS_LVL]),
            .anti_lvl(st_r.ctrl[TCPWM_CB_ANTI_LVL]),
            .pos_pin(pos_pins[i]),
            .anti_pin(anti_pins[i])
         );
      end
   endgenerate

   assign rdata = st_r.rdata;
   assign peak_irq = st_r.irq;
   assign carrier_toggle_pin = st_r.toggle;
   assign phase_one_positive_pin = pos_pins[0];
   assign phase_one_anti_pin = anti_pins[0];
   assign phase_two_positive_pin = pos_pins[1];
   assign phase_two_anti_pin = anti_pins[1];
   assign phase_three_positive_pin = pos_pins[2];
   assign phase_three_anti_pin = anti_pins[2];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_peak_irq: assert property (
      (tick && !st_r.down1
       && st_r.first_phase_counter == st_r.upper_limit_compare)
      |=> peak_irq ##1 !peak_irq)
      else $error("peak did not raise a one-cycle request");
   chk_turn_down: assert property (
      (tick && st_r.first_phase_counter == st_r.upper_limit_compare)
      |=> st_r.down1
      && st_r.first_phase_counter == $past(st_r.upper_limit_compare) - 1)
      else $error("counter one did not turn down at the limit");
   chk_turn_up2: assert property (
      (tick && st_r.second_phase_counter == 16'h0000)
      |=> !st_r.down2 && st_r.second_phase_counter == 16'h0001)
      else $error("counter two did not turn up at zero");
   chk_count_step: assert property (
      (tick && !wr) |=> st_r.first_phase_counter
      != $past(st_r.first_phase_counter))
      else $error("counter one did not move on a tick");
   chk_toggle_turn: assert property (
      ((peak_ev || trough_ev) && st_r.ctrl[TCPWM_CB_TOGGLE_EN])
      |=> carrier_toggle_pin != $past(carrier_toggle_pin))
      else $error("toggle pin missed a turning point");
   chk_toggle_hold: assert property (
      !(peak_ev || trough_ev) |=> $stable(carrier_toggle_pin))
      else $error("toggle pin moved off a turning point");
   chk_cmp_hold: assert property (
      (run && !xfer_ev) |=> $stable(st_r.duty_cmp))
      else $error("compare changed outside a transfer");
   chk_xfer_load: assert property (
      xfer_ev |=> st_r.duty_cmp == $past(st_r.duty_tmp))
      else $error("transfer did not load the temporaries");
   chk_arm_buf3: assert property (
      (wr && addr == TCPWM_OFS_BUF3 && run)
      |=> st_r.tmp_valid && st_r.duty_tmp[2] == $past(wdata))
      else $error("third buffer write did not arm transfer");
   chk_read_data: assert property (
      (rd && addr == TCPWM_OFS_CNT1 && !wr)
      |=> rdata == $past(st_r.first_phase_counter)
      ##1 (rdata == 16'h0000 || $past(rd)))
      else $error("read data not presented for one cycle");
endmodule // tcpwm_top

// >>> sim/tcpwm_stage_model.sv
// Power stage model that counts active cycles on each phase pin.
`timescale 1ns/100ps
module tcpwm_stage_model (
   // Clock and window clear.
   input wire logic clk,
   input wire logic clr,
   // Active levels of the gate inputs.
   input wire logic pos_lvl,
   input wire logic anti_lvl,
   // Phase pins.
   input wire logic [2:0] pos_pin,
   input wire logic [2:0] anti_pin,
   // Active cycle counts per phase.
   output int pos_cnt [3],
   output int anti_cnt [3]
);
   always @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         pos_cnt[i] <= clr ? 0 : pos_cnt[i] + (pos_pin[i] === pos_lvl);
         anti_cnt[i] <= clr ? 0 : anti_cnt[i] + (anti_pin[i] === anti_lvl);
      end
   end
endmodule // tcpwm_stage_model

// >>> sim/tcpwm_top_test.sv
// Self-checking testbench for the three-phase complementary PWM block.
`timescale 1ns/100ps
module tcpwm_top_test;
   import tcpwm_pkg::*;
   localparam int DT = 2;
   localparam int HC = 8;
   localparam int UL = HC + DT;
   logic clk, reset, wr, rd, clr;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, v, w;
   logic peak_irq, tog;
   logic [2:0] pp, ap;
   int pos_cnt [3];
   int anti_cnt [3];
   int miscompares = 0;
   int num_checks = 0;

   tcpwm_top uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .peak_irq(peak_irq),
      .carrier_toggle_pin(tog), .phase_one_positive_pin(pp[0]),
      .phase_one_anti_pin(ap[0]), .phase_two_positive_pin(pp[1]),
      .phase_two_anti_pin(ap[1]), .phase_three_positive_pin(pp[2]),
      .phase_three_anti_pin(ap[2]));
   tcpwm_stage_model stage (.clk(clk), .clr(clr), .pos_lvl(1'b0),
      .anti_lvl(1'b0), .pos_pin(pp), .anti_pin(ap), .pos_cnt(pos_cnt),
      .anti_cnt(anti_cnt));

   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end

   task results;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Loads the carrier set while stopped, then starts with the given control.
   task setup(input logic [15:0] d, input logic [15:0] ctrl);
      wr_reg(TCPWM_OFS_CTRL, 16'h0030);
      wr_reg(TCPWM_OFS_CNT1, DT);
      wr_reg(TCPWM_OFS_CNT2, 16'h0000);
      wr_reg(TCPWM_OFS_DEAD, DT);
      wr_reg(TCPWM_OFS_HALF, HC);
      wr_reg(TCPWM_OFS_HALF_BUF, HC);
      wr_reg(TCPWM_OFS_UPPER, UL);
      wr_reg(TCPWM_OFS_UPPER_BUF, UL);
      wr_reg(TCPWM_OFS_BUF1, d);
      wr_reg(TCPWM_OFS_BUF1 + 4'h1, d);
      wr_reg(TCPWM_OFS_BUF3, d);
      wr_reg(TCPWM_OFS_CTRL, ctrl);
   endtask

   // Active (low) clocks per carrier; high widths follow the duty table.
   function automatic int exp_act(input int d, input bit anti);
      int hi;
      if (anti) begin
         hi = (d <= DT) ? 2 * HC : (d >= UL) ? 0 : 2 * (UL - d);
      end else begin
         hi = (d >= HC) ? 2 * HC : 2 * d;
      end
      return (2 * HC - hi) * TCPWM_PRESCALE;
   endfunction

   task test_reset;
      check(tog, 1'b0);
      rd_reg(TCPWM_OFS_CTRL, v);
      check({pp[0], ap[0]}, 2'b01);
      check(v, 16'h0030);
      rd_reg(4'hF, v);
      check(v, 16'h0000);
      $display("test_reset done");
   endtask

   task test_counters;
      logic [15:0] lo1, hi1, lo2, hi2;
      lo1 = 16'hFFFF;
      hi1 = 16'h0000;
      lo2 = 16'hFFFF;
      hi2 = 16'h0000;
      setup(16'h0005, 16'h0031);
      repeat (40) begin
         rd_reg(TCPWM_OFS_CNT1, v);
         if (v < lo1) lo1 = v;
         if (v > hi1) hi1 = v;
         rd_reg(TCPWM_OFS_CNT2, v);
         if (v < lo2) lo2 = v;
         if (v > hi2) hi2 = v;
      end
      check({lo1, hi1}, {16'(DT), 16'(UL)});
      check({lo2, hi2}, {16'h0000, 16'(HC)});
      wr_reg(TCPWM_OFS_CTRL, 16'h0030);
      rd_reg(TCPWM_OFS_CNT1, v);
      rd_reg(TCPWM_OFS_CNT2, w);
      check(v - w, DT);
      rd_reg(TCPWM_OFS_STATUS, v);
      check(v[TCPWM_SB_DOWN1], v[TCPWM_SB_DOWN2]);
      $display("test_counters done");
   endtask

   task test_irq_toggle;
      int ni, nt;
      logic last;
      ni = 0;
      nt = 0;
      check(tog, 1'b0);
      setup(16'h0005, 16'h0033);
      repeat (70) @(posedge clk);
      last = tog;
      repeat (128) begin
         @(posedge clk);
         #1;
         if (peak_irq === 1'b1) ni++;
         if (tog !== last) nt++;
         last = tog;
      end
      check(ni, 2);
      check(nt, 4);
      $display("test_irq_toggle done");
   endtask

   task test_buffer;
      setup(16'h0005, 16'h0031);
      wr_reg(TCPWM_OFS_BUF1, 16'h0007);
      repeat (130) @(posedge clk);
      rd_reg(TCPWM_OFS_CMP1, v);
      check(v, 16'h0005);
      wr_reg(TCPWM_OFS_CMP1, 16'h0003);
      rd_reg(TCPWM_OFS_CMP1, v);
      check(v, 16'h0005);
      wr_reg(TCPWM_OFS_DEAD, 16'h0003);
      rd_reg(TCPWM_OFS_DEAD, v);
      check(v, DT);
      wr_reg(TCPWM_OFS_BUF3, 16'h0005);
      repeat (70) @(posedge clk);
      rd_reg(TCPWM_OFS_CMP1, v);
      check(v, 16'h0007);
      $display("test_buffer done");
   endtask

   task test_duty;
      int dl [8] = '{0, 1, DT, 5, HC, HC + 1, UL, UL + 2};
      setup(16'h0005, 16'h0031);
      foreach (dl[i]) begin
         wr_reg(TCPWM_OFS_BUF1, dl[i]);
         wr_reg(TCPWM_OFS_BUF1 + 4'h1, 16'h0000);
         wr_reg(TCPWM_OFS_BUF3, UL);
         repeat (140) @(posedge clk);
         @(posedge clk) clr <= 1'b1;
         @(posedge clk) clr <= 1'b0;
         repeat (64) @(posedge clk);
         #1;
         check(pos_cnt[0], exp_act(dl[i], 0));
         check(anti_cnt[0], exp_act(dl[i], 1));
         check(pos_cnt[1], 2 * HC * TCPWM_PRESCALE);
         check(anti_cnt[1], 0);
         check(pos_cnt[2], 0);
         check(anti_cnt[2], 2 * HC * TCPWM_PRESCALE);
      end
      wr_reg(TCPWM_OFS_CTRL, 16'h003D);
      repeat (8) @(posedge clk);
      check({pp[2], ap[1], pp[1]}, 3'b001);
      $display("test_duty done");
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end

   initial begin
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      clr = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      #1;
      test_reset();
      test_counters();
      test_irq_toggle();
      test_buffer();
      test_duty();
      results();
   end
endmodule // tcpwm_top_test
